// file: dv/paper_tape_format_loader_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tape_loader_checker (
  input wire logic                        ref_clk,
  input wire logic                        nrst,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [7:0]                  paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire tape_loader_pkg::tape_char_t slowChar,
  input wire tape_loader_pkg::tape_char_t fastChar,
  input wire tape_loader_pkg::mem_wr_t    memWr
);
  // ------------------------------
  // Mode tracking
  // ------------------------------
  logic        fmtQ;
  logic        srcQ;
  logic [23:0] histQ;
  logic        selV;
  logic [7:0]  selD;
  assign selV = srcQ ? slowChar.valid : fastChar.valid;
  assign selD = srcQ ? slowChar.data : fastChar.data;
  // Follows CTRL at once; stimulus waits out the switch sync lag
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fmtQ <= 1'b0;
      srcQ <= 1'b0;
    end else if (psel && penable && pready && pwrite && paddr == 8'h00) begin
      fmtQ <= pwdata[tape_loader_pkg::CTRL_FMT];
      srcQ <= pwdata[tape_loader_pkg::CTRL_SWBASE];
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      histQ <= '0;
    end else if (selV && selD != tape_loader_pkg::LEADER_CODE) begin
      histQ <= {histQ[17:0], selD[5:0]};
    end
  end
  // ------------------------------
  // Properties
  // ------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a one-cycle answer");
  a_err_map: assert property (pready |-> pslverr == (paddr > 8'h10))
    else $error("pslverr wrong for address");
  a_write_pulse: assert property (memWr.valid |=> !memWr.valid)
    else $error("write strobe longer than one cycle");
  a_write_cause: assert property (memWr.valid |-> $past(selV, 2))
    else $error("write without a character two cycles before");
  a_leader_drop: assert property (
    selV && selD == 8'h80 |-> ##2 !memWr.valid)
    else $error("leader character caused a write");
  a_mark_no_write: assert property (
    !fmtQ && selV && selD[7:6] == 2'b01 |-> ##2 !memWr.valid)
    else $error("address mark caused a write");
  a_pair_data: assert property (
    memWr.valid && !fmtQ |-> memWr.data == histQ[11:0])
    else $error("word-pair data not joined from last two characters");
  a_pair_addr: assert property (
    memWr.valid && !fmtQ |-> memWr.addr == histQ[23:12])
    else $error("word-pair address not joined from marked pair");
  c_pair_write: cover property (memWr.valid && !fmtQ);
  c_block_write: cover property (memWr.valid && fmtQ);
  c_bad_addr: cover property (pready && pslverr);
endmodule
bind paper_tape_format_loader tape_loader_checker u_chk (.ref_clk, .nrst,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .slowChar, .fastChar, .memWr);
`default_nettype wire

// file: dv/tape_reader_model.sv
`timescale 1ns/1ps
`default_nettype none
module tape_reader_model #(
  parameter int GAP = 2
) (
  input  wire logic                       ref_clk,
  input  wire logic                       nrst,
  input  wire logic                       sendReq,
  input  wire logic [7:0]                 sendByte,
  output var tape_loader_pkg::tape_char_t charOut,
  output logic                            idle
);
  logic       pendQ;
  logic [7:0] byteQ;
  int         cntQ;
  assign idle = !pendQ && !charOut.valid;
  // Data lines show junk between strobes so stale values never match
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pendQ   <= 1'b0;
      byteQ   <= 8'h00;
      cntQ    <= 0;
      charOut <= '0;
    end else if (sendReq) begin
      pendQ <= 1'b1;
      byteQ <= sendByte;
      cntQ  <= GAP;
    end else if (pendQ && cntQ > 0) begin
      cntQ <= cntQ - 1;
    end else if (pendQ) begin
      pendQ   <= 1'b0;
      charOut <= '{valid: 1'b1, data: byteQ};
    end else if (charOut.valid) begin
      charOut <= '{valid: 1'b0, data: ~charOut.data};
    end
  end
endmodule
`default_nettype wire

// file: dv/test_paper_tape_format_loader.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin nChecks++; if ((g) !== (e)) begin badCount++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module test_paper_tape_format_loader;
  typedef struct packed {
    logic [11:0] addr;
    logic [11:0] data;
  } row_t;
  logic                        ref_clk, nrst, psel, penable, pwrite;
  logic                        pready, pslverr, rerr;
  logic                        slowReq, fastReq, slowIdle, fastIdle;
  logic [7:0]                  paddr, slowByte, fastByte;
  logic [31:0]                 pwdata, prdata, rdat;
  tape_loader_pkg::tape_char_t slowChar, fastChar;
  tape_loader_pkg::mem_wr_t    memWr;
  tape_loader_pkg::mem_wr_t    gotQ [$];
  int                          badCount, nChecks;
  row_t rows [4] = '{'{12'h080, 12'hfff}, '{12'hfff, 12'h000},
    '{12'h000, 12'ha5c}, '{12'h03f, 12'h3c0}};
  logic [7:0] tape [16] = '{8'h42, 8'h00, 8'h3a, 8'h00, 8'h0a, 8'h3f,
    8'h1a, 8'h3e, 8'h3c, 8'h02, 8'h42, 8'h3f, 8'h00, 8'h2b, 8'h08, 8'h07};
  row_t blk [5] = '{'{12'h080, 12'he80}, '{12'h081, 12'h2bf},
    '{12'h082, 12'h6be}, '{12'h083, 12'hf02}, '{12'h0bf, 12'h02b}};

  paper_tape_format_loader dut (.ref_clk, .nrst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .slowChar, .fastChar,
    .memWr);
  tape_reader_model #(.GAP(6)) slowRdr (.ref_clk, .nrst, .sendReq(slowReq),
    .sendByte(slowByte), .charOut(slowChar), .idle(slowIdle));
  tape_reader_model #(.GAP(2)) fastRdr (.ref_clk, .nrst, .sendReq(fastReq),
    .sendByte(fastByte), .charOut(fastChar), .idle(fastIdle));

  // ------------------------------
  // Bus and tape tasks
  // ------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic sendChar(input logic slow, input logic [7:0] b);
    int n;
    @(posedge ref_clk);
    {slowReq, fastReq, slowByte, fastByte} <= {slow, !slow, b, b};
    @(posedge ref_clk);
    {slowReq, fastReq} <= 2'b00;
    n = 0;
    do begin @(posedge ref_clk); n++; end while (!(slowIdle && fastIdle) && n < 50);
  endtask
  // Waits out the console switch synchroniser before the tape starts
  task automatic startLoad(input logic slow, input logic [31:0] ctrl);
    apb(1'b1, tape_loader_pkg::OFF_CTRL, ctrl);
    repeat (6) @(posedge ref_clk);
    gotQ.delete();
    repeat (2) sendChar(slow, 8'h80);
  endtask
  task automatic endLoad(input logic slow);
    repeat (2) sendChar(slow, 8'h80);
    repeat (4) @(posedge ref_clk);
    apb(1'b0, tape_loader_pkg::OFF_RESULT, 32'h0);
  endtask
  task automatic completeRun();
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge ref_clk) if (memWr.valid === 1'b1) gotQ.push_back(memWr);
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    #800000;
    badCount++;
    completeRun();
  end

  // ------------------------------
  // Sequence
  // ------------------------------
  initial begin
    {nrst, psel, penable, pwrite, slowReq, fastReq} = '0;
    {paddr, pwdata, slowByte, fastByte} = '0;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    // Word-pair rows on the fast reader
    startLoad(1'b0, 32'h0000_0001);
    foreach (rows[i]) begin
      sendChar(1'b0, {2'b01, rows[i].addr[11:6]});
      sendChar(1'b0, {2'b00, rows[i].addr[5:0]});
      sendChar(1'b0, {2'b00, rows[i].data[11:6]});
      sendChar(1'b0, {2'b00, rows[i].data[5:0]});
    end
    endLoad(1'b0);
    `CHK("pair count", 4, gotQ.size())
    foreach (rows[i]) `CHK("pair write", {1'b1, rows[i]}, gotQ[i])
    // Origin block on the slow reader, good checksum
    startLoad(1'b1, 32'h0001_0003);
    foreach (tape[i]) sendChar(1'b1, tape[i]);
    endLoad(1'b1);
    `CHK("good result", 32'h0, rdat)
    `CHK("block count", 5, gotQ.size())
    foreach (blk[i]) `CHK("block write", {1'b1, blk[i]}, gotQ[i])
    // Fast reader, bad checksum, stray character on the idle reader
    tape[15] = 8'h05;
    startLoad(1'b0, 32'h0000_0003);
    foreach (tape[i]) begin
      if (i == 4) sendChar(1'b1, 8'h3f);
      sendChar(1'b0, tape[i]);
    end
    endLoad(1'b0);
    `CHK("bad result", 32'h2, rdat)
    foreach (blk[i]) `CHK("fast write", {1'b1, blk[i]}, gotQ[i])
    apb(1'b0, tape_loader_pkg::OFF_STATUS, 32'h0);
    `CHK("sum error", 1'b1, rdat[tape_loader_pkg::STAT_ERR])
    `CHK("load done", 1'b1, rdat[tape_loader_pkg::STAT_DONE])
    apb(1'b0, tape_loader_pkg::OFF_COUNT, 32'h0);
    `CHK("word count", 32'h5, rdat)
    apb(1'b0, tape_loader_pkg::OFF_ADDR, 32'h0);
    `CHK("next address", 32'h0c0, rdat)
    // Unmapped read
    apb(1'b0, 8'h14, 32'h0);
    `CHK("unmapped data", 32'h0, rdat)
    `CHK("unmapped err", 1'b1, rerr)
    // Mid-run reset clears the control register and the bus answer
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    `CHK("reset ready", 1'b0, pready)
    `CHK("reset write", 1'b0, memWr.valid)
    nrst <= 1'b1;
    apb(1'b0, tape_loader_pkg::OFF_CTRL, 32'h0);
    `CHK("reset ctrl", 32'h0, rdat)
    completeRun();
  end
endmodule
`default_nettype wire

// file: rtl/char_select.sv
`timescale 1ns/1ps
`default_nettype none
module char_select (
  input  wire logic                        ref_clk,
  input  wire logic                        nrst,
  input  wire logic                        slowSel,
  input  wire tape_loader_pkg::tape_char_t slowChar,
  input  wire tape_loader_pkg::tape_char_t fastChar,
  output tape_loader_pkg::tape_char_t      selChar
);
  // Readers are synchronous sources; one registered stage is enough
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      selChar <= '0;
    end else if (slowSel) begin
      selChar <= slowChar;
    end else begin
      selChar <= fastChar;
    end
  end
endmodule
`default_nettype wire

// file: rtl/paper_tape_format_loader.sv
`timescale 1ns/1ps
`default_nettype none
module paper_tape_format_loader (
  input  wire logic                        ref_clk,
  input  wire logic                        nrst,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Tape readers, same clock, one-cycle strobes
  input  wire tape_loader_pkg::tape_char_t slowChar,
  input  wire tape_loader_pkg::tape_char_t fastChar,
  // Memory write port
  output tape_loader_pkg::mem_wr_t         memWr
);
  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic                        enable_q;
  tape_loader_pkg::fmt_t       fmt_q;
  logic [11:0]                 consoleSwitchWord_q;
  logic                        done_q;
  logic                        err_q;
  logic [11:0]                 resultAccumulator_q;
  logic [11:0]                 curAddr_q;
  logic [15:0]                 wordCount_q;
  tape_loader_pkg::state_t     state_q;
  logic [5:0]                  highHalf_q;
  logic                        highIsAddr_q;
  logic                        expectData_q;
  logic [11:0]                 pendAddr_q;
  logic [11:0]                 heldWord_q;
  logic                        heldValid_q;
  logic [11:0]                 sum_q;
  logic [11:0]                 heldSum_q;
  logic                        startPulse;
  logic [7:0]                  syncSw;
  tape_loader_pkg::tape_char_t inChar;

  // Console switches may come from a panel; sync bits 7:0 as pins for STATUS; source select reads them unsynced
  pin_sync #(
    .W (8)
  ) u_sw_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .pinIn   (consoleSwitchWord_q[7:0]),
    .syncOut (syncSw)
  );

  char_select u_sel (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .slowSel  (consoleSwitchWord_q[tape_loader_pkg::SRC_SEL_BIT]),
    .slowChar (slowChar),
    .fastChar (fastChar),
    .selChar  (inChar)
  );

  // ------------------------------------------------------------------
  // APB slave, zero wait states
  // ------------------------------------------------------------------
  logic apbWr;
  logic apbRd;
  assign apbWr = psel && penable && pwrite;
  assign apbRd = psel && !penable && !pwrite;
  assign startPulse = apbWr && paddr == tape_loader_pkg::OFF_CTRL
                      && pwdata[tape_loader_pkg::CTRL_ENABLE];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      enable_q            <= 1'b0;
      fmt_q               <= tape_loader_pkg::FMT_WORD_PAIR;
      consoleSwitchWord_q <= tape_loader_pkg::WORD_RST;
    end else if (apbWr && paddr == tape_loader_pkg::OFF_CTRL) begin
      enable_q <= pwdata[tape_loader_pkg::CTRL_ENABLE];
      fmt_q    <= pwdata[tape_loader_pkg::CTRL_FMT]
                  ? tape_loader_pkg::FMT_ORIGIN_BLOCK
                  : tape_loader_pkg::FMT_WORD_PAIR;
      consoleSwitchWord_q <= pwdata[tape_loader_pkg::CTRL_SWBASE +: 12];
    end else if (state_q == tape_loader_pkg::ST_DONE) begin
      enable_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && paddr > tape_loader_pkg::OFF_COUNT;
      if (apbRd) begin
        case (paddr)
          tape_loader_pkg::OFF_CTRL:
            prdata <= {4'h0, consoleSwitchWord_q, 14'h0000,
                       fmt_q == tape_loader_pkg::FMT_ORIGIN_BLOCK, enable_q};
          tape_loader_pkg::OFF_STATUS:
            prdata <= {21'h000000, syncSw, err_q, done_q, enable_q};
          tape_loader_pkg::OFF_RESULT:
            prdata <= {20'h00000, resultAccumulator_q};
          tape_loader_pkg::OFF_ADDR:
            prdata <= {20'h00000, curAddr_q};
          tape_loader_pkg::OFF_COUNT:
            prdata <= {16'h0000, wordCount_q};
          default:
            prdata <= '0;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // Character decode
  // ------------------------------------------------------------------
  logic        isLeader;
  logic        ch7;
  logic [5:0]  payload;
  logic [11:0] word;
  logic        bodyChar;
  assign ch7      = inChar.data[tape_loader_pkg::CH7_BIT];
  assign isLeader = inChar.data == tape_loader_pkg::LEADER_CODE;
  assign payload  = inChar.data[tape_loader_pkg::HALF_W-1:0];
  assign word     = {highHalf_q, payload};
  // Body chars have channel 8 clear
  assign bodyChar = inChar.valid
                    && !inChar.data[tape_loader_pkg::CH8_BIT];

  // ------------------------------------------------------------------
  // Loader sequencer
  // ------------------------------------------------------------------
  logic pairWrite;
  logic blockWrite;
  logic originSet;
  logic trailerEnd;
  logic loadStart;
  // Data pair after an address pair
  assign pairWrite  = state_q == tape_loader_pkg::ST_LOW && bodyChar
                      && fmt_q == tape_loader_pkg::FMT_WORD_PAIR
                      && !highIsAddr_q && expectData_q;
  // Next body character releases held word
  assign blockWrite = state_q == tape_loader_pkg::ST_HIGH && bodyChar
                      && fmt_q == tape_loader_pkg::FMT_ORIGIN_BLOCK
                      && heldValid_q;
  assign originSet  = state_q == tape_loader_pkg::ST_LOW && bodyChar
                      && fmt_q == tape_loader_pkg::FMT_ORIGIN_BLOCK
                      && highIsAddr_q;
  // Trailer turns held word into checksum
  assign trailerEnd = state_q == tape_loader_pkg::ST_HIGH
                      && inChar.valid && isLeader;
  assign loadStart  = state_q == tape_loader_pkg::ST_IDLE && startPulse;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q      <= tape_loader_pkg::ST_IDLE;
      highHalf_q   <= '0;
      highIsAddr_q <= 1'b0;
      expectData_q <= 1'b0;
      pendAddr_q   <= '0;
      heldWord_q   <= '0;
      heldValid_q  <= 1'b0;
      sum_q        <= '0;
      heldSum_q    <= '0;
    end else begin
      case (state_q)
        tape_loader_pkg::ST_IDLE: begin
          if (startPulse) begin
            state_q      <= tape_loader_pkg::ST_LEADER;
            heldValid_q  <= 1'b0;
            sum_q        <= '0;
            expectData_q <= 1'b0;
          end
        end
        tape_loader_pkg::ST_LEADER: begin
          if (bodyChar) begin
            state_q      <= tape_loader_pkg::ST_LOW;
            highHalf_q   <= payload;
            highIsAddr_q <= ch7;
            sum_q        <= sum_q + {4'h0, inChar.data};
          end
        end
        tape_loader_pkg::ST_HIGH: begin
          if (trailerEnd) begin
            state_q <= tape_loader_pkg::ST_DONE;
          end else if (bodyChar) begin
            state_q      <= tape_loader_pkg::ST_LOW;
            highHalf_q   <= payload;
            highIsAddr_q <= ch7;
            sum_q        <= sum_q + {4'h0, inChar.data};
            if (blockWrite) begin
              heldValid_q <= 1'b0;
            end
          end
        end
        tape_loader_pkg::ST_LOW: begin
          if (bodyChar) begin
            state_q <= tape_loader_pkg::ST_HIGH;
            sum_q   <= sum_q + {4'h0, inChar.data};
            if (fmt_q == tape_loader_pkg::FMT_WORD_PAIR) begin
              if (highIsAddr_q) begin
                pendAddr_q   <= word;
                expectData_q <= 1'b1;
              end else if (expectData_q) begin
                expectData_q <= 1'b0;
              end
            end else if (!highIsAddr_q) begin
              // Possible checksum: hold, sum excludes this pair
              heldWord_q  <= word;
              heldValid_q <= 1'b1;
              heldSum_q   <= sum_q - {4'h0, 2'b00, highHalf_q};
            end
          end
        end
        tape_loader_pkg::ST_DONE: begin
          state_q <= tape_loader_pkg::ST_IDLE;
        end
        default: begin
          state_q <= tape_loader_pkg::ST_IDLE;
        end
      endcase
      // Clearing enable mid-tape abandons the load without a result
      if (!enable_q && state_q != tape_loader_pkg::ST_IDLE
          && state_q != tape_loader_pkg::ST_DONE) begin
        state_q <= tape_loader_pkg::ST_IDLE;
      end
    end
  end

  // ------------------------------------------------------------------
  // Result and status flags
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      done_q              <= 1'b0;
      err_q               <= 1'b0;
      resultAccumulator_q <= '0;
    end else if (loadStart) begin
      done_q <= 1'b0;
      err_q  <= 1'b0;
    end else if (trailerEnd) begin
      done_q <= 1'b1;
      if (fmt_q == tape_loader_pkg::FMT_ORIGIN_BLOCK) begin
        resultAccumulator_q <= heldSum_q - heldWord_q;
        err_q <= heldValid_q && heldSum_q != heldWord_q;
      end else begin
        resultAccumulator_q <= '0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Load address and word count
  // ------------------------------------------------------------------
  // Consecutive addresses from the origin; a word-pair write loads its pair address
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      curAddr_q <= '0;
    end else if (pairWrite) begin
      curAddr_q <= pendAddr_q;
    end else if (originSet) begin
      curAddr_q <= word;
    end else if (blockWrite) begin
      curAddr_q <= curAddr_q + 12'h001;
    end
  end

  // Count wraps silently; software reads it only as a sanity figure
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wordCount_q <= '0;
    end else if (loadStart) begin
      wordCount_q <= '0;
    end else if (pairWrite || blockWrite) begin
      wordCount_q <= wordCount_q + 16'h0001;
    end
  end

  // ------------------------------------------------------------------
  // Memory write port
  // ------------------------------------------------------------------
  // Registered so the strobe never glitches on decode paths
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      memWr <= '0;
    end else begin
      memWr.valid <= pairWrite || blockWrite;
      if (pairWrite) begin
        memWr.addr <= pendAddr_q;
        memWr.data <= word;
      end else if (blockWrite) begin
        memWr.addr <= curAddr_q;
        memWr.data <= heldWord_q;
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Change counts only once the two late stages agree
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      syncOut <= '0;
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        syncOut <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/tape_loader_pkg.sv
package tape_loader_pkg;

  localparam int          CHAR_W      = 8;
  localparam int          WORD_W      = 12;
  localparam int          HALF_W      = 6;
  localparam int          CH8_BIT     = 7;
  localparam int          CH7_BIT     = 6;
  localparam int          SRC_SEL_BIT = 0;
  localparam logic [7:0]  LEADER_CODE = 8'h80;
  localparam logic [11:0] WORD_RST    = 12'h000;
  localparam int          SYNC_STAGES = 3;

  // Software-visible register offsets (byte addresses)
  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_STATUS  = 8'h04;
  localparam logic [7:0]  OFF_RESULT  = 8'h08;
  localparam logic [7:0]  OFF_ADDR    = 8'h0c;
  localparam logic [7:0]  OFF_COUNT   = 8'h10;

  // Control and status fields
  localparam int          CTRL_ENABLE = 0;
  localparam int          CTRL_FMT    = 1;
  localparam int          CTRL_SWBASE = 16;
  localparam int          STAT_BUSY   = 0;
  localparam int          STAT_DONE   = 1;
  localparam int          STAT_ERR    = 2;

  typedef enum logic [1:0] {
    FMT_WORD_PAIR    = 2'b00,
    FMT_ORIGIN_BLOCK = 2'b01
  } fmt_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_LEADER = 3'b001,
    ST_HIGH   = 3'b010,
    ST_LOW    = 3'b011,
    ST_DONE   = 3'b100
  } state_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  data;
  } tape_char_t;

  typedef struct packed {
    logic        valid;
    logic [11:0] addr;
    logic [11:0] data;
  } mem_wr_t;

endpackage
